// >>> hw/eeprom_ctrl_pkg.sv
// Constants, command codes and register map of the serial EEPROM controller.
// Assumes a 50 MHz system clock; every timing count is derived from it here.
package eeprom_ctrl_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses within the block)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_COMMAND = 8'hb0;
    localparam logic [7:0] OFS_DATA = 8'hb4;
    localparam logic [7:0] OFS_STATUS = 8'hb8;
    localparam logic [7:0] OFS_MASK = 8'hbc;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BUSY_BIT = 31;
    localparam int CMD_LSB = 28;
    localparam int EW_BIT = 10;
    localparam int TIMEOUT_BIT = 9;
    localparam int LOADED_BIT = 8;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_TIMEOUT = 1;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RESET_ADDR = 8'h00;
    localparam logic [7:0] RESET_DATA = 8'h00;
    localparam logic [1:0] RESET_MASK = 2'h0;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 50;
    localparam int TIMEOUT_MS = 30;
    localparam int TIMEOUT_CYCLES = TIMEOUT_MS * 1000 * CLK_MHZ;
    localparam int SCLK_HALF_NS = 500;
    localparam int SCLK_HALF_CYCLES = (SCLK_HALF_NS * CLK_MHZ + 999) / 1000;
    localparam int CS_GAP_NS = 250;
    localparam int CS_GAP_CYCLES = (CS_GAP_NS * CLK_MHZ + 999) / 1000;

    // ------------------------------------------------------------
    // Serial frame
    // ------------------------------------------------------------
    localparam logic [4:0] FRAME_BITS = 5'h0b;
    localparam logic [4:0] FRAME_DATA_BITS = 5'h13;
    localparam logic [3:0] RX_BITS = 4'h8;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_ERASE = 2'h3;
    localparam logic [1:0] OP_MISC = 2'h0;
    localparam logic [1:0] MISC_EW_ON = 2'h3;
    localparam logic [1:0] MISC_EW_OFF = 2'h0;
    localparam logic [1:0] MISC_FILL = 2'h1;
    localparam logic [1:0] MISC_WIPE = 2'h2;
    localparam logic [7:0] SIGNATURE = 8'ha5;
    localparam logic [2:0] STATION_BYTES = 3'h6;

    typedef enum logic [2:0] {
        cmd_read,
        cmd_erase_write_disable,
        cmd_erase_write_enable,
        cmd_write,
        cmd_write_every_location,
        cmd_erase,
        cmd_bulk_erase,
        cmd_reload
    } cmd_e;

endpackage : eeprom_ctrl_pkg

// >>> hw/serial_shifter.sv
// Bit engine for the three-wire EEPROM link: shifts a frame out MSB first,
// then clocks in_count bits in. Assumes din is already synchronised to hclk.
`timescale 1ns/10ps
module serial_shifter #(
    parameter int HALF = eeprom_ctrl_pkg::SCLK_HALF_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic start,
    input wire logic [4:0] out_count,
    input wire logic [3:0] in_count,
    input wire logic [18:0] tx,
    input wire logic din,
    output logic done,
    output logic [7:0] rx,
    output logic sclk,
    output logic dout,
    output logic dout_oe_n
);
    import eeprom_ctrl_pkg::*;

    localparam int DW = $clog2(HALF + 1);
    typedef enum logic [1:0] {SH_IDLE, SH_LOW, SH_HIGH} phase_e;
    typedef struct packed {
        phase_e phase;
        logic [DW-1:0] div;
        logic [4:0] out_left;
        logic [3:0] in_left;
        logic [18:0] sreg;
        logic [7:0] rx;
        logic sclk, dout, oe_n, done;
    } shift_s;

    shift_s s, n;

    always_comb begin
        n = s;
        n.done = 1'b0;
        case (s.phase)
            SH_IDLE: begin
                if (start) begin
                    n.sreg = tx;
                    n.out_left = out_count;
                    n.in_left = in_count;
                    n.dout = tx[18];
                    n.oe_n = 1'b0;
                    n.div = '0;
                    n.phase = SH_LOW;
                end
            end
            SH_LOW: begin
                if (s.div == DW'(HALF - 1)) begin
                    n.div = '0;
                    n.sclk = 1'b1;
                    n.phase = SH_HIGH;
                end else begin
                    n.div = s.div + DW'(1);
                end
            end
            SH_HIGH: begin
                if (s.div == DW'(HALF - 1)) begin
                    n.div = '0;
                    n.sclk = 1'b0;
                    n.phase = SH_LOW;
                    if (s.out_left != 5'h00) begin
                        n.out_left = s.out_left - 5'h01;
                        n.sreg = {s.sreg[17:0], 1'b0};
                        n.dout = s.sreg[17];
                    end else begin
                        // Sampled late in the high phase, after the part has driven it
                        n.in_left = s.in_left - 4'h1;
                        n.rx = {s.rx[6:0], din};
                    end
                    if (n.out_left == 5'h00) begin
                        n.oe_n = 1'b1;
                    end
                    if (n.out_left == 5'h00 && n.in_left == 4'h0) begin
                        n.phase = SH_IDLE;
                        n.dout = 1'b0;
                        n.done = 1'b1;
                    end
                end else begin
                    n.div = s.div + DW'(1);
                end
            end
            default: n.phase = SH_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
            s.oe_n <= 1'b1;
        end else if (ce) begin
            s <= n;
        end
    end

    assign done = s.done;
    assign rx = s.rx;
    assign sclk = s.sclk;
    assign dout = s.dout;
    assign dout_oe_n = s.oe_n;

    default clocking dc @(posedge hclk iff ce); endclocking
    default disable iff (!hresetn);

    a_first_bit_msb: assert property (
        s.phase == SH_IDLE && start |=> dout == $past(tx[18]) && !dout_oe_n
    ) else $error("first bit out is not the frame msb");

endmodule : serial_shifter

// >>> hw/nv_controller.sv
// Serial EEPROM command controller with an AHB-Lite register slave.
// Assumes a single-word AHB-Lite master and a three-wire EEPROM on the pins.
//
// The AHB-Lite register port was decided locally.
`timescale 1ns/10ps

module nv_controller #(
    parameter int TIMEOUT = eeprom_ctrl_pkg::TIMEOUT_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic irq,
    output logic eeprom_cs,
    output logic eeprom_sclk,
    input wire logic serial_data_line_in,
    output logic serial_data_line_out,
    output logic serial_data_line_oe_n,
    output logic [47:0] station_address,
    output logic station_address_ready_flag
);
    import eeprom_ctrl_pkg::*;

    localparam int TW = $clog2(TIMEOUT + 1);
    localparam int GW = $clog2(CS_GAP_CYCLES + 1);

    typedef enum logic [1:0] {M_IDLE, M_SHIFT, M_GAP, M_POLL} mstate_e;

    typedef struct packed {
        mstate_e state;
        cmd_e cmd;
        logic [7:0] addr;
        logic [7:0] data;
        logic go, busy, timeout, loaded, ew_on, sig_ok, cs, start, irq;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic [2:0] idx;
        logic [GW-1:0] gap;
        logic [TW-1:0] tcnt;
        logic [47:0] station;
        logic dp_valid, dp_write;
        logic [7:0] dp_addr;
        logic [31:0] hrdata;
        logic din_s1, din_s2;
    } ctrl_s;

    ctrl_s s, n;

    logic sh_done;
    logic [7:0] sh_rx;
    logic [18:0] sh_tx;
    logic [4:0] sh_out;
    logic [3:0] sh_in;
    logic done;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [18:0] frame_of(cmd_e c, logic [7:0] a, logic [7:0] d);
        case (c)
            cmd_read: frame_of = {1'b1, OP_READ, a, 8'h00};
            cmd_write: frame_of = {1'b1, OP_WRITE, a, d};
            cmd_erase: frame_of = {1'b1, OP_ERASE, a, 8'h00};
            cmd_erase_write_enable: frame_of = {1'b1, OP_MISC, MISC_EW_ON, 14'h0000};
            cmd_erase_write_disable: frame_of = {1'b1, OP_MISC, MISC_EW_OFF, 14'h0000};
            cmd_write_every_location: frame_of = {1'b1, OP_MISC, MISC_FILL, 6'h00, d};
            cmd_bulk_erase: frame_of = {1'b1, OP_MISC, MISC_WIPE, 14'h0000};
            default: frame_of = {1'b1, OP_READ, a, 8'h00};
        endcase
    endfunction : frame_of

    function automatic logic [31:0] read_word(ctrl_s v, logic [7:0] a);
        logic [31:0] w;
        w = 32'h0000_0000;
        case (a)
            OFS_COMMAND: begin
                w[BUSY_BIT] = v.busy;
                w[CMD_LSB +: 3] = v.cmd;
                w[EW_BIT] = v.ew_on;
                w[TIMEOUT_BIT] = v.timeout;
                w[LOADED_BIT] = v.loaded;
                w[7:0] = v.addr;
            end
            OFS_DATA: w[7:0] = v.data;
            OFS_STATUS: w[1:0] = v.irq_stat;
            OFS_MASK: w[1:0] = v.irq_mask;
            default: w = 32'h0000_0000;
        endcase
        return w;
    endfunction : read_word

    function automatic logic waits_ready(cmd_e c);
        return c == cmd_write || c == cmd_write_every_location ||
               c == cmd_erase || c == cmd_bulk_erase;
    endfunction : waits_ready

    // Reload reads walk the index; read, write and erase frames use the address field
    always_comb begin
        sh_tx = frame_of(s.cmd, (s.cmd == cmd_reload) ? {5'h00, s.idx} : s.addr, s.data);
        sh_out = (s.cmd == cmd_write || s.cmd == cmd_write_every_location)
                 ? FRAME_DATA_BITS : FRAME_BITS;
        sh_in = (s.cmd == cmd_read || s.cmd == cmd_reload) ? RX_BITS : 4'h0;
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        n = s;
        done = 1'b0;
        n.start = 1'b0;
        n.din_s1 = serial_data_line_in;
        n.din_s2 = s.din_s1;

        // Bus write, data phase; command and data are locked while busy
        if (s.dp_valid && s.dp_write) begin
            case (s.dp_addr)
                OFS_COMMAND: begin
                    if (!s.busy) begin
                        n.addr = hwdata[7:0];
                        n.cmd = cmd_e'(hwdata[CMD_LSB +: 3]);
                        if (hwdata[BUSY_BIT]) begin
                            n.go = 1'b1;
                            n.busy = 1'b1;
                        end
                    end
                end
                OFS_DATA: begin
                    if (!s.busy) begin
                        n.data = hwdata[7:0];
                    end
                end
                OFS_STATUS: n.irq_stat = s.irq_stat & ~hwdata[1:0];
                OFS_MASK: n.irq_mask = hwdata[1:0];
                default: n.irq_mask = s.irq_mask;
            endcase
        end

        case (s.state)
            M_IDLE: begin
                if (s.go) begin
                    n.go = 1'b0;
                    n.timeout = 1'b0;
                    n.idx = 3'h0;
                    n.sig_ok = 1'b0;
                    if (s.cmd == cmd_reload) begin
                        n.loaded = 1'b0;
                    end
                    n.cs = 1'b1;
                    n.start = 1'b1;
                    n.state = M_SHIFT;
                end
            end
            M_SHIFT: begin
                if (sh_done) begin
                    n.cs = 1'b0;
                    n.gap = '0;
                    case (s.cmd)
                        cmd_read: begin
                            n.data = sh_rx;
                            done = 1'b1;
                        end
                        // Mirror of the part's own write-enable latch
                        cmd_erase_write_enable: begin
                            n.ew_on = 1'b1;
                            done = 1'b1;
                        end
                        cmd_erase_write_disable: begin
                            n.ew_on = 1'b0;
                            done = 1'b1;
                        end
                        cmd_reload: begin
                            n.idx = s.idx + 3'h1;
                            if (s.idx == 3'h0) begin
                                n.sig_ok = (sh_rx == SIGNATURE);
                            end else begin
                                n.station = {s.station[39:0], sh_rx};
                            end
                            if (s.idx == 3'h0 && sh_rx != SIGNATURE) begin
                                done = 1'b1;
                            end else if (s.idx == STATION_BYTES) begin
                                n.loaded = 1'b1;
                                done = 1'b1;
                            end else begin
                                n.state = M_GAP;
                            end
                        end
                        // Only programming frames wait for the ready answer
                        default: n.state = M_GAP;
                    endcase
                end
            end
            M_GAP: begin
                if (s.gap == GW'(CS_GAP_CYCLES - 1)) begin
                    n.cs = 1'b1;
                    if (s.cmd == cmd_reload) begin
                        n.start = 1'b1;
                        n.state = M_SHIFT;
                    end else begin
                        n.tcnt = '0;
                        n.state = M_POLL;
                    end
                end else begin
                    n.gap = s.gap + GW'(1);
                end
            end
            M_POLL: begin
                if (s.din_s2) begin
                    n.cs = 1'b0;
                    done = 1'b1;
                end else if (s.tcnt == TW'(TIMEOUT - 1)) begin
                    n.cs = 1'b0;
                    n.timeout = 1'b1;
                    n.irq_stat[IRQ_TIMEOUT] = 1'b1;
                    done = 1'b1;
                end else begin
                    n.tcnt = s.tcnt + TW'(1);
                end
            end
            default: n.state = M_IDLE;
        endcase

        // Events land after the clear, so a same-cycle event is kept
        if (done) begin
            n.busy = 1'b0;
            n.state = M_IDLE;
            n.irq_stat[IRQ_DONE] = 1'b1;
        end
        n.irq = |(n.irq_stat & n.irq_mask);

        // Address phase; read data built from the updated copy
        n.dp_valid = hsel && htrans[1] && hready;
        if (n.dp_valid) begin
            n.dp_addr = haddr[7:0];
            n.dp_write = hwrite;
            if (!hwrite) begin
                n.hrdata = read_word(n, haddr[7:0]);
            end
        end
    end

    // Power-up load of the station address starts straight out of reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
            s.addr <= RESET_ADDR;
            s.data <= RESET_DATA;
            s.irq_mask <= RESET_MASK;
            s.cmd <= cmd_reload;
            s.go <= 1'b1;
            s.busy <= 1'b1;
        end else if (ce) begin
            s <= n;
        end
    end

    serial_shifter #(
        .HALF(SCLK_HALF_CYCLES)
    ) u_shift (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .start(s.start),
        .out_count(sh_out),
        .in_count(sh_in),
        .tx(sh_tx),
        .din(s.din_s2),
        .done(sh_done),
        .rx(sh_rx),
        .sclk(eeprom_sclk),
        .dout(serial_data_line_out),
        .dout_oe_n(serial_data_line_oe_n)
    );

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign hrdata = s.hrdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign irq = s.irq;
    assign eeprom_cs = s.cs;
    assign station_address = s.station;
    assign station_address_ready_flag = s.loaded;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cc @(posedge hclk iff ce); endclocking
    default disable iff (!hresetn);

    sequence launch_seq;
        s.state == M_IDLE && s.go;
    endsequence

    sequence shift_seq;
        s.start && s.state == M_SHIFT && s.busy && s.cs;
    endsequence

    a_launch_frame: assert property (launch_seq |=> shift_seq)
        else $error("command launch did not start a frame");

    a_busy_held: assert property (s.state != M_IDLE |-> s.busy)
        else $error("busy dropped during a sequence");

    a_ew_enable_only: assert property (
        $rose(s.ew_on) |-> $past(s.cmd) == cmd_erase_write_enable
    ) else $error("write enable mirror set by another command");

    a_ew_disable_only: assert property (
        $fell(s.ew_on) |-> $past(s.cmd) == cmd_erase_write_disable
    ) else $error("write enable mirror cleared by another command");

    a_poll_kinds: assert property (s.state == M_POLL |-> waits_ready(s.cmd))
        else $error("non-programming command waiting for ready");

    a_high_line_ends: assert property (
        s.state == M_POLL && s.din_s2 |=> !s.busy && !s.timeout && !s.cs
    ) else $error("ready answer did not end the command");

    a_timeout_cause: assert property (
        $rose(s.timeout) |-> $past(s.state) == M_POLL && !s.busy && s.state == M_IDLE
    ) else $error("time-out flag without a poll expiry");

    a_timeout_count: assert property (
        s.state == M_POLL && !s.din_s2 && s.tcnt == TW'(TIMEOUT - 1) |=> s.timeout
    ) else $error("poll ran past the time-out count");

    a_loaded_cause: assert property (
        $rose(s.loaded) |-> $past(s.cmd) == cmd_reload && $past(s.sig_ok)
    ) else $error("ready flag set without a valid reload");

    a_frame_address: assert property (
        s.start && (s.cmd == cmd_write || s.cmd == cmd_erase) |-> sh_tx[15:8] == s.addr
    ) else $error("frame address differs from the address field");

    a_frame_data: assert property (
        s.start && (s.cmd == cmd_write || s.cmd == cmd_write_every_location)
        |-> sh_tx[7:0] == s.data && sh_out == FRAME_DATA_BITS
    ) else $error("write frame does not carry the data byte");

endmodule : nv_controller

// >>> verif/eeprom_model.sv
// Behavioural three-wire serial EEPROM, 256 bytes, for the controller bench.
// Assumes the controller frames: start bit, 2-bit opcode, 8-bit address, data.
`timescale 1ns/10ps
module eeprom_model (
    input wire logic cs,
    input wire logic sclk,
    input wire logic din,
    input wire logic present,
    output logic dq,
    output logic dq_oe
);
    logic [7:0] mem [256];
    logic [18:0] sh;
    logic [7:0] q;
    logic ew, rd, rdy, pend;
    int n;
    // ------------------------------------------------------------
    // Frame decode
    // ------------------------------------------------------------
    initial begin
        ew = 1'b0;
        {rd, rdy, pend, q, sh} = '0;
        n = 0;
        for (int i = 0; i < 256; i++) mem[i] = 8'(i);
        mem[0] = 8'ha5;
    end
    // Ready poll shows a driven high, not a stale read bit
    always @(posedge cs) begin
        n = 0;
        rd = 1'b0;
        if (rdy) dq = 1'b1;
    end
    // Ready shows on the poll that follows a programming frame
    always @(negedge cs) begin
        rdy = pend;
        pend = 1'b0;
    end
    always @(posedge sclk) if (cs) begin
        sh = {sh[17:0], din};
        n++;
        if (n == 11) begin
            case (sh[9:8])
                2'h2: begin q = mem[sh[7:0]]; rd = 1'b1; end
                2'h3: begin if (ew) mem[sh[7:0]] = 8'hff; pend = 1'b1; end
                2'h0: case (sh[7:6])
                    2'h3: ew = 1'b1;
                    2'h0: ew = 1'b0;
                    2'h2: begin
                        if (ew) for (int i = 0; i < 256; i++) mem[i] = 8'hff;
                        pend = 1'b1;
                    end
                    default: ;
                endcase
                default: ;
            endcase
        end
        if (n == 19 && sh[17:16] == 2'h1) begin
            if (ew) mem[sh[15:8]] = sh[7:0];
            pend = 1'b1;
        end
        if (n == 19 && sh[17:16] == 2'h0 && sh[15:14] == 2'h1) begin
            if (ew) for (int i = 0; i < 256; i++) mem[i] = sh[7:0];
            pend = 1'b1;
        end
    end
    always @(negedge sclk) if (cs && rd) begin
        dq = q[7];
        q = {q[6:0], ~q[7]};
    end
    assign dq_oe = present && cs && (rd || rdy);
endmodule : eeprom_model

// >>> verif/tb_nv_controller.sv
// Self-checking bench for the EEPROM controller over AHB-Lite.
// Assumes zero-wait-state slave and the model in eeprom_model.sv.
`timescale 1ns/10ps
module tb_nv_controller;
    import eeprom_ctrl_pkg::*;
    logic hclk, hresetn, hsel, hwrite, present, pull, line;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0] htrans;
    logic hreadyout, hresp, irq, cs, sclk, d_out, d_oe_n, m_dq, m_oe, flag;
    logic [47:0] station;
    int n_fail = 0;
    int cmp_count = 0;
    // Released line falls to the pull level
    assign line = !d_oe_n ? d_out : (m_oe ? m_dq : pull);
    nv_controller #(.TIMEOUT(200)) dut_u (.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .irq(irq), .eeprom_cs(cs), .eeprom_sclk(sclk),
        .serial_data_line_in(line), .serial_data_line_out(d_out),
        .serial_data_line_oe_n(d_oe_n), .station_address(station),
        .station_address_ready_flag(flag));
    eeprom_model part_u (.cs(cs), .sclk(sclk), .din(line), .present(present),
        .dq(m_dq), .dq_oe(m_oe));
    // ------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("[FAIL] %s exp %h got %h", nm, e, g);
            n_fail++;
        end
    endtask : chk
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, 24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : ahb
    task automatic wait_idle;
        int k;
        k = 0;
        do begin
            ahb(1'b0, OFS_COMMAND, 32'h0);
            k++;
        end while (r[BUSY_BIT] !== 1'b0 && k < 5000);
        chk("busy clear", 48'h0, {47'h0, r[BUSY_BIT]});
    endtask : wait_idle
    task automatic run(input cmd_e c, input logic [7:0] a, input logic [7:0] d);
        ahb(1'b1, OFS_DATA, {24'h0, d});
        ahb(1'b1, OFS_COMMAND, {1'b1, c, 20'h0, a});
        wait_idle();
    endtask : run
    task automatic loc(input logic [7:0] a, input logic [7:0] e);
        run(cmd_read, a, 8'h00);
        ahb(1'b0, OFS_DATA, 32'h0);
        chk("location", {40'h0, e}, {16'h0, r});
    endtask : loc
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : give_verdict
    // ------------------------------------------------------------
    // Clock, watchdog, tests
    // ------------------------------------------------------------
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    initial begin
        #1000000;
        n_fail++;
        give_verdict();
    end
    initial begin
        {hsel, hwrite, htrans, haddr, hwdata, hresetn} = '0;
        present = 1'b1;
        pull = 1'b1;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, OFS_DATA, 32'h0);
        chk("data reset", 48'h0, {16'h0, r});
        ahb(1'b0, OFS_COMMAND, 32'h0);
        chk("addr reset", 48'h0, {40'h0, r[7:0]});
        wait_idle();
        chk("loaded", 48'h1, {47'h0, r[LOADED_BIT]});
        chk("station", 48'h010203040506, station);
        ahb(1'b1, OFS_DATA, 32'hffffffff);
        ahb(1'b0, OFS_DATA, 32'h0);
        chk("data bits", 48'hff, {16'h0, r});
        ahb(1'b0, 8'h40, 32'h0);
        chk("unmapped", 48'h0, {16'h0, r});
        $display("test reset done");
        run(cmd_write, 8'h12, 8'h3c);
        loc(8'h12, 8'h12);
        run(cmd_erase_write_enable, 8'h00, 8'h00);
        run(cmd_write, 8'h12, 8'h3c);
        loc(8'h12, 8'h3c);
        run(cmd_erase, 8'h12, 8'h00);
        loc(8'h12, 8'hff);
        loc(8'h13, 8'h13);
        run(cmd_write_every_location, 8'h00, 8'h5a);
        loc(8'h7f, 8'h5a);
        run(cmd_bulk_erase, 8'h00, 8'h00);
        loc(8'h7f, 8'hff);
        run(cmd_erase_write_disable, 8'h00, 8'h00);
        run(cmd_write, 8'h20, 8'h3c);
        loc(8'h20, 8'hff);
        $display("test program done");
        ahb(1'b1, OFS_MASK, 32'h1);
        repeat (2) @(posedge hclk);
        chk("irq on", 48'h1, {47'h0, irq});
        ahb(1'b1, OFS_MASK, 32'h0);
        repeat (2) @(posedge hclk);
        chk("irq masked", 48'h0, {47'h0, irq});
        ahb(1'b1, OFS_STATUS, 32'h3);
        ahb(1'b0, OFS_STATUS, 32'h0);
        chk("status clr", 48'h0, {16'h0, r});
        chk("hresp", 48'h0, {47'h0, hresp});
        $display("test irq done");
        present <= 1'b0;
        pull <= 1'b0;
        run(cmd_write, 8'h01, 8'h00);
        chk("timeout", 48'h1, {47'h0, r[TIMEOUT_BIT]});
        ahb(1'b0, OFS_STATUS, 32'h0);
        chk("status to", 48'h1, {47'h0, r[IRQ_TIMEOUT]});
        run(cmd_read, 8'h01, 8'h00);
        chk("read no to", 48'h0, {47'h0, r[TIMEOUT_BIT]});
        pull <= 1'b1;
        run(cmd_erase, 8'h01, 8'h00);
        chk("erase no to", 48'h0, {47'h0, r[TIMEOUT_BIT]});
        run(cmd_reload, 8'h00, 8'h00);
        chk("not loaded", 48'h0, {46'h0, r[LOADED_BIT], flag});
        $display("test absent done");
        give_verdict();
    end
endmodule : tb_nv_controller
